// File: verilog/flash_psram_host_pkg.sv
package flash_psram_host_pkg;

   // Host command codes
   typedef enum logic [3:0] {
      OP_FLASH_READ  = 4'h0,
      OP_FLASH_WRITE = 4'h1,
      OP_RAM_READ    = 4'h2,
      OP_RAM_WRITE   = 4'h3,
      OP_RAM_SLEEP   = 4'h4,
      OP_RAM_WAKE    = 4'h5,
      OP_FLASH_RESET = 4'h6,
      OP_SET_PROTECT = 4'h7
   } op_type;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_SETUP   = 4'h2,
      ST_STROBE  = 4'h4,
      ST_RECOVER = 4'h8
   } state_type;

   // Bit positions of the protect-control word in cmd_wdata
   localparam int PROT_LIFT_BIT = 0;
   localparam int PROT_ACCEL_BIT = 1;
   localparam int PROT_ID_VOLT_BIT = 2;

   // Pin reset values
   localparam logic PROT_PIN_RESET = 1'b0;
   localparam logic RAM_AWAKE_RESET = 1'b1;

   // Timing in ns and derived cycle counts
   localparam int CLK_NS = 50;
   localparam int SYNC_STAGES = 2;
   localparam int FLASH_ACCESS_NS = 70;
   localparam int RAM_ACCESS_NS = 60;
   localparam int WRITE_PULSE_NS = 60;
   localparam int SETUP_NS = 50;
   localparam int RECOVER_NS = 50;
   localparam int RESET_PULSE_NS = 500;
   localparam int OUT_DISABLE_MAX_NS = 1000;
   localparam int FLASH_ACCESS_CYC = (FLASH_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAM_ACCESS_CYC = (RAM_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int OUT_DISABLE_MAX_CYC = OUT_DISABLE_MAX_NS / CLK_NS;
   // Reads hold output enable long enough for access plus the synchroniser
   localparam int FLASH_READ_CYC = FLASH_ACCESS_CYC + SYNC_STAGES + 1;
   localparam int RAM_READ_CYC = RAM_ACCESS_CYC + SYNC_STAGES + 1;

endpackage : flash_psram_host_pkg

// File: verilog/pin_sync.sv
// Two-stage synchroniser; the first stage feeds only the second
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] d, // Asynchronous input
   output logic [WIDTH-1:0] q // Synchronised output
);
   logic [WIDTH-1:0] meta_q;

   // Both stages reset to a constant
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : pin_sync

// File: verilog/flash_psram_host.sv
// Functional notes
// (RQ1) Host drives only the legal pin combinations of the bus.
// (RQ2) Flash and RAM are never selected at the same time.
// (RQ3) RAM output-disable state is never held longer than 1 us.
// (RQ4) Flash write has output enable high and write enable low.
// (RQ5) RAM reads drive at least one lane enable low.
// (RQ6) RAM reads return the full 16-bit word.
// (RQ7) Lane enables gate low and high bytes on RAM writes.
// (RQ8) Address is valid before any RAM read or write starts.
// (RQ9) Secondary RAM select low means power-down, entered from standby.
// (RQ10) Flash reset low with RAM deselected resets flash, floats data.
// (RQ11) Protect pin low blocks program/erase of outer boot sectors.
// (RQ12) Protect pin high lifts boot protection; elevated level accelerates.
// (RQ13) Elevated id voltage on reset pin temporarily unprotects sectors.
// (RQ14) Flash has four physical banks grouped into two virtual banks.
// (RQ15) Reads of the other bank are served at once during writes.
// (RQ16) Sixteen small and 126 large sectors; any set erasable.
// (RQ17) Erase preprograms then erases internally.
// (RQ18) Program writes and verifies internally.
// (RQ19) Open-drain ready/busy shows program or erase in progress.
// (RQ20) Program can be suspended and resumed.
// (RQ21) Erase can be suspended and resumed.
// (RQ22) Flash sleeps on its own while the address is stable.
// (RQ23) Sleep is entered after 150 ns of stable address.
// (RQ24) With neither die selected data floats, strobes ignored.
// (RQ25) Ready/busy pulls low while busy, released on completion or reset.
module flash_psram_host (
   input wire logic sys_clk, // 20 MHz system clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic cmd_valid, // Command request
   input wire logic [3:0] cmd_op, // Command code
   input wire logic [21:0] cmd_addr, // Word address
   input wire logic [15:0] cmd_wdata, // Write data or protect word
   input wire logic [1:0] cmd_lane_n, // RAM write lanes, bit0 low byte
   output logic cmd_ready, // Command accepted when high with valid
   output logic rsp_valid, // One-cycle completion pulse
   output logic [15:0] rsp_rdata, // Read data, held until next read
   output logic rsp_error, // Completion was refused
   output logic flash_busy, // Flash program or erase running
   output logic [19:0] common_address, // Shared address pins
   output logic [1:0] flash_upper_address, // Flash-only address pins
   output logic flash_select_n, // Flash select
   output logic ram_select_primary_n, // RAM primary select
   output logic ram_select_secondary, // RAM secondary select, low sleeps
   output logic output_enable_n, // Shared output enable
   output logic write_enable_n, // Shared write enable
   output logic low_lane_enable_n, // RAM low byte lane
   output logic high_lane_enable_n, // RAM high byte lane
   input wire logic [15:0] shared_data_bus_in, // Data pins, input
   output logic [15:0] shared_data_bus_out, // Data pins, output
   output logic shared_data_bus_oe, // Data pins driven when high
   output logic flash_reset_n, // Flash hardware reset
   output logic boot_protect_accel_pin, // Low protects boot sectors
   output logic accel_voltage_en, // Switches pin to acceleration level
   output logic elevated_id_voltage_en, // Switches reset pin to id level
   input wire logic flash_ready_busy_n // Open-drain ready/busy pin
);
   logic rst_sync_n;
   logic [15:0] data_sync;
   logic ready_sync_n;
   flash_psram_host_pkg::state_type state_q, state_d;
   logic [5:0] cnt_q, cnt_d;
   flash_psram_host_pkg::op_type op_q, op_d;
   logic [1:0] cmd_lane_q;
   logic accept, is_ram, is_rw, refuse, imm_op;
   logic strobe_d, active_d, read_d, write_d, flash_d, ram_d, reset_d;

   // Reset release through two flops
   pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(rst_sync_n)
   );

   // Pins from the device pass two flops before use
   pin_sync #(.WIDTH(16), .RESET_VAL(16'h0000)) u_data_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .d(shared_data_bus_in),
      .q(data_sync)
   );

   pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_ready_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .d(flash_ready_busy_n),
      .q(ready_sync_n)
   );

   // Command decode
   assign accept = cmd_valid && cmd_ready;
   assign is_ram = (cmd_op == flash_psram_host_pkg::OP_RAM_READ) ||
                   (cmd_op == flash_psram_host_pkg::OP_RAM_WRITE);
   assign is_rw = is_ram ||
                  (cmd_op == flash_psram_host_pkg::OP_FLASH_READ) ||
                  (cmd_op == flash_psram_host_pkg::OP_FLASH_WRITE);
   // RAM read or write while asleep is refused with an error
   assign refuse = is_ram && !ram_select_secondary; // [RQ9]
   assign imm_op = !is_rw &&
                   (cmd_op != flash_psram_host_pkg::OP_FLASH_RESET);

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         flash_psram_host_pkg::ST_IDLE: begin
            if (accept && is_rw && !refuse) begin
               // Address goes out with selects high first [RQ8]
               state_d = flash_psram_host_pkg::ST_SETUP;
               cnt_d = 6'(flash_psram_host_pkg::SETUP_CYC - 1);
            end else if (accept &&
                         cmd_op == flash_psram_host_pkg::OP_FLASH_RESET) begin
               state_d = flash_psram_host_pkg::ST_STROBE;
               cnt_d = 6'(flash_psram_host_pkg::RESET_PULSE_CYC - 1);
            end
         end
         flash_psram_host_pkg::ST_SETUP: begin
            if (cnt_q == 6'h00) begin
               state_d = flash_psram_host_pkg::ST_STROBE;
               case (op_q)
                  flash_psram_host_pkg::OP_FLASH_READ:
                     cnt_d = 6'(flash_psram_host_pkg::FLASH_READ_CYC - 1);
                  flash_psram_host_pkg::OP_RAM_READ:
                     cnt_d = 6'(flash_psram_host_pkg::RAM_READ_CYC - 1);
                  default:
                     cnt_d = 6'(flash_psram_host_pkg::WRITE_PULSE_CYC - 1);
               endcase
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         flash_psram_host_pkg::ST_STROBE: begin
            if (cnt_q == 6'h00) begin
               state_d = flash_psram_host_pkg::ST_RECOVER;
               cnt_d = 6'(flash_psram_host_pkg::RECOVER_CYC - 1);
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         flash_psram_host_pkg::ST_RECOVER: begin
            if (cnt_q == 6'h00) begin
               state_d = flash_psram_host_pkg::ST_IDLE;
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         default: begin
            state_d = flash_psram_host_pkg::ST_IDLE;
            cnt_d = 6'h00;
         end
      endcase
   end

   // Sequencer state and counter
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= flash_psram_host_pkg::ST_IDLE;
         cnt_q <= 6'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Latched command; held for the whole access so pins stay stable
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         op_q <= flash_psram_host_pkg::OP_FLASH_READ;
         common_address <= 20'h00000;
         flash_upper_address <= 2'h0;
         shared_data_bus_out <= 16'h0000;
         cmd_lane_q <= 2'h3;
      end else if (accept && is_rw) begin
         op_q <= flash_psram_host_pkg::op_type'(cmd_op);
         common_address <= cmd_addr[19:0]; // [RQ8]
         flash_upper_address <= cmd_addr[21:20];
         shared_data_bus_out <= cmd_wdata;
         cmd_lane_q <= cmd_lane_n;
      end else if (accept) begin
         op_q <= flash_psram_host_pkg::op_type'(cmd_op);
      end
   end

   // Pin intent; a reset strobes in its accept cycle, so decode the new op
   assign op_d = accept ? flash_psram_host_pkg::op_type'(cmd_op) : op_q;
   assign strobe_d = (state_d == flash_psram_host_pkg::ST_STROBE);
   assign active_d = (state_d != flash_psram_host_pkg::ST_IDLE);
   assign read_d = (op_d == flash_psram_host_pkg::OP_FLASH_READ) ||
                   (op_d == flash_psram_host_pkg::OP_RAM_READ);
   assign write_d = (op_d == flash_psram_host_pkg::OP_FLASH_WRITE) ||
                    (op_d == flash_psram_host_pkg::OP_RAM_WRITE);
   assign flash_d = (op_d == flash_psram_host_pkg::OP_FLASH_READ) ||
                    (op_d == flash_psram_host_pkg::OP_FLASH_WRITE);
   assign ram_d = (op_d == flash_psram_host_pkg::OP_RAM_READ) ||
                  (op_d == flash_psram_host_pkg::OP_RAM_WRITE);
   assign reset_d = (op_d == flash_psram_host_pkg::OP_FLASH_RESET);

   // Selects fall with a strobe: no RAM output disable [RQ1] [RQ3]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         flash_select_n <= 1'b1;
         ram_select_primary_n <= 1'b1;
         output_enable_n <= 1'b1;
         write_enable_n <= 1'b1;
         low_lane_enable_n <= 1'b1;
         high_lane_enable_n <= 1'b1;
         shared_data_bus_oe <= 1'b0;
         flash_reset_n <= 1'b1;
      end else begin
         // Only one die per access; RAM stays off during reset [RQ2] [RQ10]
         flash_select_n <= !(strobe_d && flash_d);
         ram_select_primary_n <= !(strobe_d && ram_d); // [RQ2]
         output_enable_n <= !(strobe_d && read_d);
         // Write: output enable stays high, write enable low [RQ4]
         write_enable_n <= !(strobe_d && write_d); // [RQ4]
         if (strobe_d && op_q == flash_psram_host_pkg::OP_RAM_READ) begin
            // Whole word read, both lanes on [RQ5] [RQ6]
            low_lane_enable_n <= 1'b0;
            high_lane_enable_n <= 1'b0;
         end else if (strobe_d &&
                      op_q == flash_psram_host_pkg::OP_RAM_WRITE) begin
            low_lane_enable_n <= cmd_lane_q[0]; // [RQ7]
            high_lane_enable_n <= cmd_lane_q[1]; // [RQ7]
         end else begin
            low_lane_enable_n <= 1'b1;
            high_lane_enable_n <= 1'b1;
         end
         // Data driven from setup through recovery for hold margin
         shared_data_bus_oe <= active_d && write_d; // [RQ24]
         flash_reset_n <= !(strobe_d && reset_d); // [RQ10]
      end
   end

   // RAM power-down, entered and left only while idle (standby) [RQ9]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ram_select_secondary <= flash_psram_host_pkg::RAM_AWAKE_RESET;
      end else if (accept &&
                   cmd_op == flash_psram_host_pkg::OP_RAM_SLEEP) begin
         ram_select_secondary <= 1'b0; // [RQ9]
      end else if (accept &&
                   cmd_op == flash_psram_host_pkg::OP_RAM_WAKE) begin
         ram_select_secondary <= 1'b1;
      end
   end

   // Protect and high-voltage switch controls [RQ11] [RQ12] [RQ13]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         boot_protect_accel_pin <= flash_psram_host_pkg::PROT_PIN_RESET;
         accel_voltage_en <= 1'b0;
         elevated_id_voltage_en <= 1'b0;
      end else if (accept &&
                   cmd_op == flash_psram_host_pkg::OP_SET_PROTECT) begin
         boot_protect_accel_pin <=
            cmd_wdata[flash_psram_host_pkg::PROT_LIFT_BIT]; // [RQ11] [RQ12]
         accel_voltage_en <=
            cmd_wdata[flash_psram_host_pkg::PROT_ACCEL_BIT]; // [RQ12]
         elevated_id_voltage_en <=
            cmd_wdata[flash_psram_host_pkg::PROT_ID_VOLT_BIT]; // [RQ13]
      end
   end

   // Response: read data sampled on the last strobe cycle [RQ6]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         if (state_q == flash_psram_host_pkg::ST_STROBE &&
             cnt_q == 6'h00 && read_d) begin
            rsp_rdata <= data_sync; // [RQ6]
         end
         if (accept && (imm_op || (is_rw && refuse))) begin
            rsp_valid <= 1'b1;
            rsp_error <= is_rw && refuse;
         end else begin
            rsp_valid <= (state_q == flash_psram_host_pkg::ST_RECOVER) &&
                         (cnt_q == 6'h00);
            rsp_error <= 1'b0;
         end
      end
   end

   // Ready only in idle; flash reads are allowed while it is busy [RQ15]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_ready <= 1'b0;
         flash_busy <= 1'b0;
      end else begin
         cmd_ready <= (state_d == flash_psram_host_pkg::ST_IDLE) &&
                      !(accept && imm_op);
         flash_busy <= !ready_sync_n; // [RQ19] [RQ25]
      end
   end

endmodule : flash_psram_host

// File: dv/flash_psram_host_assertions.sv
module flash_psram_host_assertions (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [19:0] common_address, // Shared address
   input wire logic flash_select_n, // Flash select
   input wire logic ram_select_primary_n, // RAM select
   input wire logic ram_select_secondary, // RAM awake
   input wire logic output_enable_n, // Output enable
   input wire logic write_enable_n, // Write enable
   input wire logic low_lane_enable_n, // Low lane
   input wire logic high_lane_enable_n, // High lane
   input wire logic shared_data_bus_oe, // Host drives data
   input wire logic flash_reset_n // Flash reset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   logic [5:0] idle_q; // Cycles spent in RAM output disable
   logic ram_sel;
   assign ram_sel = !ram_select_primary_n && ram_select_secondary;
   // No saturation: the limit fires long before the count wraps
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) idle_q <= 6'h00;
      else if (ram_sel && output_enable_n && write_enable_n) begin
         idle_q <= idle_q + 6'h01;
      end else idle_q <= 6'h00;
   end
   property p_one_die;
      !(!flash_select_n && ram_sel);
   endproperty
   a_one_die: assert property (p_one_die)
      else $error("two dies selected");
   property p_idle;
      idle_q <= 6'h14;
   endproperty
   a_idle: assert property (p_idle)
      else $error("output disable held too long");
   property p_flash_wr;
      !flash_select_n && !write_enable_n |-> output_enable_n;
   endproperty
   a_flash_wr: assert property (p_flash_wr)
      else $error("flash write with output enable low");
   property p_rd_strobe;
      $fell(flash_select_n) && write_enable_n |->
         (!flash_select_n && !output_enable_n) [*5] ##1 flash_select_n;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe)
      else $error("flash read strobe length wrong");
   property p_lanes;
      ram_sel && !output_enable_n |->
         !(low_lane_enable_n && high_lane_enable_n);
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("RAM read with no lane enabled");
   property p_addr;
      $fell(ram_select_primary_n) |-> $stable(common_address);
   endproperty
   a_addr: assert property (p_addr)
      else $error("address moved as RAM select fell");
   property p_reset;
      $fell(flash_reset_n) |-> (!flash_reset_n && ram_select_primary_n) [*8];
   endproperty
   a_reset: assert property (p_reset)
      else $error("flash reset pulse short or RAM selected");
   property p_no_fight;
      !output_enable_n |-> !shared_data_bus_oe;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("host drives data during a read");
endmodule : flash_psram_host_assertions

bind flash_psram_host flash_psram_host_assertions i_chk (
   .sys_clk, .rst_n, .common_address, .flash_select_n,
   .ram_select_primary_n, .ram_select_secondary, .output_enable_n,
   .write_enable_n, .low_lane_enable_n, .high_lane_enable_n,
   .shared_data_bus_oe, .flash_reset_n
);

// File: dv/mcp_device_model.sv
module mcp_device_model #(
   parameter int PROG_NS = 1500,
   parameter logic [6:0] LOCKED_SECTOR = 7'h60 // Group kept protected
) (
   input wire logic [19:0] common_address, // Shared address
   input wire logic [1:0] flash_upper_address, // Flash address top
   input wire logic flash_select_n, // Flash select
   input wire logic ram_select_primary_n, // RAM select
   input wire logic ram_select_secondary, // RAM awake
   input wire logic output_enable_n, // Output enable
   input wire logic write_enable_n, // Write enable
   input wire logic low_lane_enable_n, // Low lane
   input wire logic high_lane_enable_n, // High lane
   input wire logic [15:0] shared_data_bus_out, // Host data
   input wire logic shared_data_bus_oe, // Host drives data
   input wire logic flash_reset_n, // Flash reset
   input wire logic boot_protect_accel_pin, // Boot protect level
   input wire logic accel_voltage_en, // Acceleration level
   input wire logic elevated_id_voltage_en, // Id level on reset pin
   output logic [15:0] shared_data_bus_in, // Level on the data pins
   output logic flash_ready_busy_n = 1'b1 // Open drain with pull-up
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] ram_mem [int];
   logic [15:0] flash_mem [int];
   logic [15:0] junk = 16'h5a5a;
   time busy_until = 0;
   wire [21:0] fa = {flash_upper_address, common_address};
   wire ram_on = !ram_select_primary_n && ram_select_secondary;
   wire fl_on = !flash_select_n && flash_reset_n;
   // Two 4 Kword boot sectors at each end of the array
   wire boot = fa < 22'h002000 || fa >= 22'h3fe000;
   wire grp = fa[21:15] == LOCKED_SECTOR; // One 32 Kword sector
   // Physical banks of 8, 24, 24 and 8 Mbit
   wire [1:0] bank = fa < 22'h080000 ? 2'h0 : fa < 22'h200000 ? 2'h1 :
                     fa < 22'h380000 ? 2'h2 : 2'h3;
   logic [1:0] busy_bank = 2'h0;
   // Floating pins change every cycle so stale data never passes
   always #50 junk = ~junk;
   // Writes land just after write enable falls: lanes and selects
   // change on the same edge, so wait for them to settle
   always @(negedge write_enable_n) begin
      #5;
      if (ram_on && output_enable_n) begin
         if (!low_lane_enable_n) ram_mem[common_address][7:0] =
            shared_data_bus_out[7:0];
         if (!high_lane_enable_n) ram_mem[common_address][15:8] =
            shared_data_bus_out[15:8];
      end
      if (fl_on && output_enable_n && !(boot && !boot_protect_accel_pin) &&
          !(grp && !elevated_id_voltage_en)) begin
         flash_mem[fa] = shared_data_bus_out;
         busy_bank = bank;
         busy_until = $time + (accel_voltage_en ? PROG_NS / 2 : PROG_NS);
      end
   end
   // Hardware reset aborts the running program
   always @(negedge flash_reset_n) busy_until = 0;
   always #10 flash_ready_busy_n = !($time < busy_until);
   // Host drive wins, then a selected reader, else the pins float
   always @* begin
      if (shared_data_bus_oe) shared_data_bus_in = shared_data_bus_out;
      else if (ram_on && !output_enable_n &&
               !(low_lane_enable_n && high_lane_enable_n)) begin
         shared_data_bus_in = ram_mem.exists(common_address) ?
                              ram_mem[common_address] : junk;
      end else if (fl_on && !output_enable_n &&
                   (flash_ready_busy_n || bank != busy_bank)) begin
         shared_data_bus_in = flash_mem.exists(fa) ? flash_mem[fa] : 16'hffff;
      end else shared_data_bus_in = junk;
   end
endmodule : mcp_device_model

// File: dv/testbench.sv
`define chk(act, exp) begin \
   num_checks++; \
   if ((act) !== (exp)) begin \
      bad_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, act, exp); \
   end \
end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
   logic [3:0] cmd_op = 4'h0;
   logic [21:0] cmd_addr = 22'h000000;
   logic [15:0] cmd_wdata = 16'h0000;
   logic [1:0] cmd_lane_n = 2'h0;
   logic cmd_ready, rsp_valid, rsp_error, flash_busy, flash_select_n;
   logic ram_select_primary_n, ram_select_secondary, output_enable_n;
   logic write_enable_n, low_lane_enable_n, high_lane_enable_n;
   logic shared_data_bus_oe, flash_reset_n, boot_protect_accel_pin;
   logic accel_voltage_en, elevated_id_voltage_en, flash_ready_busy_n;
   logic [15:0] rsp_rdata, shared_data_bus_in, shared_data_bus_out, got;
   logic [19:0] common_address;
   logic [1:0] flash_upper_address;
   logic got_err, lift = 1'b0, idv = 1'b0;
   int bad_count = 0, num_checks = 0;
   int ram_m [int];
   int flash_m [int];
   flash_psram_host i_flash_psram_host (
      .sys_clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
      .cmd_lane_n, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_error,
      .flash_busy, .common_address, .flash_upper_address, .flash_select_n,
      .ram_select_primary_n, .ram_select_secondary, .output_enable_n,
      .write_enable_n, .low_lane_enable_n, .high_lane_enable_n,
      .shared_data_bus_in, .shared_data_bus_out, .shared_data_bus_oe,
      .flash_reset_n, .boot_protect_accel_pin, .accel_voltage_en,
      .elevated_id_voltage_en, .flash_ready_busy_n
   );
   mcp_device_model i_mcp_device_model (
      .common_address, .flash_upper_address, .flash_select_n,
      .ram_select_primary_n, .ram_select_secondary, .output_enable_n,
      .write_enable_n, .low_lane_enable_n, .high_lane_enable_n,
      .shared_data_bus_out, .shared_data_bus_oe, .flash_reset_n,
      .boot_protect_accel_pin, .accel_voltage_en, .elevated_id_voltage_en,
      .shared_data_bus_in, .flash_ready_busy_n
   );
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task tmo;
      bad_count++;
      wrap_up();
   endtask : tmo
   // One command: wait for ready, hold valid one edge, catch the pulse
   task automatic do_cmd(input logic [3:0] op, input logic [21:0] a,
                         input logic [15:0] d, input logic [1:0] ln);
      int n;
      for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
      if (cmd_ready !== 1'b1) tmo();
      {cmd_op, cmd_addr, cmd_wdata, cmd_lane_n} = {op, a, d, ln};
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
      if (rsp_valid !== 1'b1) tmo();
      {got, got_err} = {rsp_rdata, rsp_error};
      @(negedge sys_clk);
   endtask : do_cmd
   task automatic wait_busy(input logic v);
      int n;
      for (n = 0; n < 100 && flash_busy !== v; n++) @(negedge sys_clk);
      if (flash_busy !== v) tmo();
   endtask : wait_busy
   task automatic prot(input logic [2:0] d);
      do_cmd(4'h7, 22'h000000, {13'h0000, d}, 2'b00);
      {idv, lift} = {d[2], d[0]};
      got[2:0] = {elevated_id_voltage_en, accel_voltage_en,
                  boot_protect_accel_pin};
      `chk(got[2:0], d)
   endtask : prot
   // Reference: boot ends locked while the pin is low, whatever the id
   // level; the locked sector group opens only at id level
   task automatic fl_wr(input logic [21:0] a, input logic [15:0] d);
      do_cmd(4'h1, a, d, 2'b00);
      if (((a >= 22'h002000 && a < 22'h3fe000) || lift) &&
          (a[21:15] != 7'h60 || idv)) flash_m[a] = d;
   endtask : fl_wr
   function automatic logic [15:0] fl_exp(input int a);
      return flash_m.exists(a) ? 16'(flash_m[a]) : 16'hffff;
   endfunction : fl_exp
   task automatic ram_wr(input logic [21:0] a, input logic [15:0] d,
                         input logic [1:0] ln);
      int m;
      m = {ln[1] ? 8'h00 : 8'hff, ln[0] ? 8'h00 : 8'hff};
      do_cmd(4'h3, a, d, ln);
      ram_m[a] = (ram_m[a] & ~m) | (int'(d) & m);
   endtask : ram_wr
   initial begin
      logic [21:0] a;
      logic [15:0] d;
      void'($urandom(32'h99c3e0ad));
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      fl_wr(22'h000010, 16'h1234);
      do_cmd(4'h0, 22'h000010, 16'h0000, 2'b00);
      `chk(got, fl_exp(22'h000010))
      prot(3'b001);
      fl_wr(22'h200100, 16'hbeef);
      wait_busy(1'b1);
      `chk(flash_busy, 1'b1)
      do_cmd(4'h0, 22'h000020, 16'h0000, 2'b00);
      `chk(got, fl_exp(22'h000020))
      wait_busy(1'b0);
      do_cmd(4'h0, 22'h200100, 16'h0000, 2'b00);
      `chk(got, fl_exp(22'h200100))
      prot(3'b100);
      fl_wr(22'h3ff000, 16'h0f0f);
      fl_wr(22'h300040, 16'h3c3c);
      wait_busy(1'b1);
      wait_busy(1'b0);
      do_cmd(4'h0, 22'h3ff000, 16'h0000, 2'b00);
      `chk(got, fl_exp(22'h3ff000))
      do_cmd(4'h0, 22'h300040, 16'h0000, 2'b00);
      `chk(got, fl_exp(22'h300040))
      prot(3'b011);
      fl_wr(22'h100000, 16'ha5a5);
      wait_busy(1'b1);
      do_cmd(4'h6, 22'h000000, 16'h0000, 2'b00);
      `chk(flash_busy, 1'b0)
      // Every lane mask over one word, then random full words
      for (int l = 0; l < 4; l++) begin
         ram_wr(22'h000040, 16'($urandom), 2'(l));
         do_cmd(4'h2, 22'h000040, 16'h0000, 2'b00);
         `chk(got, 16'(ram_m[22'h000040]))
      end
      repeat (6) begin
         a = 22'($urandom_range(0, 20'hfffff));
         ram_wr(a, 16'($urandom), 2'b00);
         do_cmd(4'h2, a, 16'h0000, 2'b00);
         `chk(got, 16'(ram_m[a]))
      end
      do_cmd(4'h4, 22'h000000, 16'h0000, 2'b00);
      `chk(ram_select_secondary, 1'b0)
      do_cmd(4'h2, a, 16'h0000, 2'b00);
      `chk(got_err, 1'b1)
      do_cmd(4'h5, 22'h000000, 16'h0000, 2'b00);
      do_cmd(4'h2, a, 16'h0000, 2'b00);
      `chk(got_err, 1'b0)
      wrap_up();
   end
endmodule : testbench
